// file: shared/byte_load_cmp_map.svh
/*
  Register offsets, field positions, reset values and operation codes
  of the signed byte load and compare engine.
  Assumes it is included by its bare name in the package and the design.
*/
`ifndef BYTE_LOAD_CMP_MAP_SVH
`define BYTE_LOAD_CMP_MAP_SVH

// Byte offsets on the register bus, one aligned word each
`define OFS_SRC1 8'h00
`define OFS_SRC2 8'h04
`define OFS_GUARD 8'h08
`define OFS_CMD 8'h0c
`define OFS_DEST 8'h10
`define OFS_STATUS 8'h14

// Command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_IMM_LSB 8
`define CMD_IMM_MSB 14

// Status word fields
`define STAT_BUSY 0
`define STAT_APER 1
`define STAT_SKIP 2

// Operation codes
`define OPC_LOADB_IDX 3'h0
`define OPC_CMP_LE 3'h1
`define OPC_CMP_LEI 3'h2
`define OPC_CMP_LT 3'h3
`define OPC_CMP_LTI 3'h4

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_CMD 10'h000

// Default register aperture window
`define APER_BASE_DEF 32'hefe0_0000
`define APER_SIZE_DEF 32'h0020_0000

`endif

// file: shared/byte_load_cmp_pkg.sv
/*
  Types shared by the signed byte load and compare engine.
  Assumes the map header sits in the include path.
*/
`include "byte_load_cmp_map.svh"

package byte_load_cmp_pkg;

  // Operations the engine understands
  typedef enum logic [2:0] {
    OP_LOADB_IDX = `OPC_LOADB_IDX,
    OP_CMP_LE = `OPC_CMP_LE,
    OP_CMP_LEI = `OPC_CMP_LEI,
    OP_CMP_LT = `OPC_CMP_LT,
    OP_CMP_LTI = `OPC_CMP_LTI
  } op_e;

  // Engine states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_EXEC = 3'h2,
    S_LOAD = 3'h4
  } state_e;

  // One issued operation
  typedef struct packed {
    logic [2:0] op;
    logic [6:0] imm;
  } cmd_s;

  // Operands of the ordering unit
  typedef struct packed {
    logic [31:0] lhs;
    logic [31:0] rhs;
    logic strict;
  } cmp_s;

endpackage

// file: verilog/signed_order_cmp.sv
/*
  Signed ordering unit: lhs >= rhs, or lhs > rhs when strict.
  Assumes purely combinational use by the engine on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module signed_order_cmp (
  // Operands
  input wire byte_load_cmp_pkg::cmp_s operands,
  // Result
  output logic greater
);

  // Only the two native orderings exist; the less forms swap operands
  always_comb begin
    if (operands.strict) begin
      greater = $signed(operands.lhs) > $signed(operands.rhs);
    end else begin
      greater = $signed(operands.lhs) >= $signed(operands.rhs);
    end
  end

endmodule

`default_nettype wire

// file: verilog/byte_load_cmp.sv
/*
  Guarded signed byte load with indexed address and four guarded signed
  compares, with an Avalon-MM register slave and a byte port to the cache.
  Assumes the cache port and the bus run on SYS_CLK; no synchroniser.
*/
// The Avalon-MM register port and the register offsets were left to the implementer.
// Functional notes
// - Byte at src1+src2, sign-extended, to destination
// - Byte load ignores byte-order setting
// - Register aperture byte load gives undefined result
// - True guard writes destination, touches cacheable status
// - False guard load: no write, no side effect
// - Register less-or-equal yields one or zero
// - Less-or-equal runs as swapped greater-or-equal
// - Immediate less-or-equal against signed 7-bit modifier
// - Register less-than, equal gives zero
// - Less-than runs as swapped greater-than
// - Compares write destination only with true guard
// - Immediate less-than against signed modifier
`timescale 1ns/1ns
`default_nettype none
`include "byte_load_cmp_map.svh"

module byte_load_cmp #(
  parameter logic [31:0] APER_BASE = `APER_BASE_DEF,
  parameter logic [31:0] APER_SIZE = `APER_SIZE_DEF
) (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Byte port to the data cache
  output logic MEM_REQ,
  output logic [31:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_CACHEABLE,
  output logic CACHE_TOUCH,
  // Result towards the register file
  output logic RESULT_WE,
  output logic [31:0] RESULT
);

  // Merge written bytes into a stored word
  function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Sign extension of the loaded byte
  function automatic logic [31:0] sext8(input logic [7:0] b);
    return {{24{b[7]}}, b};
  endfunction

  // Sign extension of the operation modifier
  function automatic logic [31:0] sext7(input logic [6:0] n);
    return {{25{n[6]}}, n};
  endfunction

  // Bus state
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] src1_q, src1_d;
  logic [31:0] src2_q, src2_d;
  logic [31:0] guard_q, guard_d;
  byte_load_cmp_pkg::cmd_s cmd_q, cmd_d;
  logic req, stall, accept, issue;

  // Engine state
  byte_load_cmp_pkg::state_e state_q, state_d;
  logic [31:0] dest_q, dest_d;
  logic [31:0] addr_q, addr_d;
  logic mem_req_q, mem_req_d;
  logic we_q, we_d;
  logic touch_q, touch_d;
  logic aper_q, aper_d;
  logic skip_q, skip_d;
  logic busy;

  // Ordering unit hookup
  byte_load_cmp_pkg::cmp_s cmp_in;
  logic cmp_out;
  logic [31:0] load_addr;
  logic in_aper;

  assign busy = (state_q != byte_load_cmp_pkg::S_IDLE);
  assign req = AVS_READ | AVS_WRITE;
  // A new command waits until the engine is idle again
  assign stall = AVS_WRITE && (AVS_ADDRESS == `OFS_CMD) && busy;
  assign accept = req && ack_q && CLK_EN;
  assign issue = accept && AVS_WRITE && (AVS_ADDRESS == `OFS_CMD);
  assign AVS_WAITREQUEST = req && !accept;
  assign AVS_READDATA = rdata_q;

  // Bus next state: one wait cycle, more while a command stalls on a busy engine, then the access completes
  always_comb begin
    ack_d = req && !ack_q && !stall;
    rdata_d = rdata_q;
    src1_d = src1_q;
    src2_d = src2_q;
    guard_d = guard_q;
    cmd_d = cmd_q;
    if (req && !ack_q && AVS_READ) begin
      case (AVS_ADDRESS)
        `OFS_SRC1: rdata_d = src1_q;
        `OFS_SRC2: rdata_d = src2_q;
        `OFS_GUARD: rdata_d = guard_q;
        `OFS_CMD: rdata_d = {17'h00000, cmd_q.imm, 5'h00, cmd_q.op};
        `OFS_DEST: rdata_d = dest_q;
        `OFS_STATUS: rdata_d = {29'h00000000, skip_q, aper_q, busy};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (accept && AVS_WRITE) begin
      case (AVS_ADDRESS)
        `OFS_SRC1: src1_d = merge_be(src1_q, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_SRC2: src2_d = merge_be(src2_q, AVS_WRITEDATA, AVS_BYTEENABLE);
        `OFS_GUARD: guard_d = merge_be(guard_q, AVS_WRITEDATA,
                                       AVS_BYTEENABLE);
        `OFS_CMD: begin
          cmd_d.op = AVS_WRITEDATA[`CMD_OP_MSB:`CMD_OP_LSB];
          cmd_d.imm = AVS_WRITEDATA[`CMD_IMM_MSB:`CMD_IMM_LSB];
        end
        default: ;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
      rdata_q <= `RST_WORD;
      src1_q <= `RST_WORD;
      src2_q <= `RST_WORD;
      guard_q <= `RST_WORD;
      cmd_q <= `RST_CMD;
    end else if (CLK_EN) begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      src1_q <= src1_d;
      src2_q <= src2_d;
      guard_q <= guard_d;
      cmd_q <= cmd_d;
    end
  end

  // Wrapping sum, a negative index steps the base down
  assign load_addr = src1_q + src2_q;
  assign in_aper = (load_addr - APER_BASE) < APER_SIZE;

  // Less forms feed the native orderings with operands exchanged
  always_comb begin
    cmp_in.lhs = src2_q;
    cmp_in.rhs = src1_q;
    cmp_in.strict = 1'b0;
    case (cmd_q.op)
      byte_load_cmp_pkg::OP_CMP_LT: begin
        cmp_in.strict = 1'b1;
      end
      byte_load_cmp_pkg::OP_CMP_LEI: begin
        cmp_in.lhs = sext7(cmd_q.imm);
      end
      byte_load_cmp_pkg::OP_CMP_LTI: begin
        cmp_in.lhs = sext7(cmd_q.imm);
        cmp_in.strict = 1'b1;
      end
      default: ;
    endcase
  end

  signed_order_cmp u_order (
    .operands(cmp_in),
    .greater(cmp_out)
  );

  // Engine next state
  always_comb begin
    state_d = state_q;
    dest_d = dest_q;
    addr_d = addr_q;
    mem_req_d = mem_req_q;
    we_d = 1'b0;
    touch_d = 1'b0;
    aper_d = aper_q;
    skip_d = skip_q;
    case (state_q)
      byte_load_cmp_pkg::S_IDLE: begin
        if (issue) begin
          state_d = byte_load_cmp_pkg::S_EXEC;
        end
      end
      byte_load_cmp_pkg::S_EXEC: begin
        state_d = byte_load_cmp_pkg::S_IDLE;
        aper_d = 1'b0;
        skip_d = !guard_q[0];
        if (!guard_q[0]) begin
          // Nothing leaves the engine on a false guard
          skip_d = 1'b1;
        end else if (cmd_q.op == byte_load_cmp_pkg::OP_LOADB_IDX) begin
          if (in_aper) begin
            // Undefined there; zero is returned and flagged
            aper_d = 1'b1;
            dest_d = 32'h0000_0000;
            we_d = 1'b1;
          end else begin
            addr_d = load_addr;
            mem_req_d = 1'b1;
            state_d = byte_load_cmp_pkg::S_LOAD;
          end
        end else if (cmd_q.op <= byte_load_cmp_pkg::OP_CMP_LTI) begin
          dest_d = {31'h00000000, cmp_out};
          we_d = 1'b1;
        end
      end
      byte_load_cmp_pkg::S_LOAD: begin
        if (MEM_ACK) begin
          // One byte only, so byte order never matters
          dest_d = sext8(MEM_RDATA);
          we_d = 1'b1;
          touch_d = MEM_CACHEABLE;
          mem_req_d = 1'b0;
          state_d = byte_load_cmp_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = byte_load_cmp_pkg::S_IDLE;
        mem_req_d = 1'b0;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= byte_load_cmp_pkg::S_IDLE;
      dest_q <= `RST_WORD;
      addr_q <= `RST_WORD;
      mem_req_q <= 1'b0;
      we_q <= 1'b0;
      touch_q <= 1'b0;
      aper_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      dest_q <= dest_d;
      addr_q <= addr_d;
      mem_req_q <= mem_req_d;
      we_q <= we_d;
      touch_q <= touch_d;
      aper_q <= aper_d;
      skip_q <= skip_d;
    end
  end

  assign MEM_REQ = mem_req_q;
  assign MEM_ADDR = addr_q;
  assign CACHE_TOUCH = touch_q;
  assign RESULT_WE = we_q;
  assign RESULT = dest_q;
  // Checks
  default clocking chk_clk @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  logic exec_go;
  assign exec_go = CLK_EN && (state_q == byte_load_cmp_pkg::S_EXEC);

  a_load_result: assert property (
    CLK_EN && state_q == byte_load_cmp_pkg::S_LOAD && MEM_ACK
    |=> RESULT_WE && RESULT == {{24{$past(MEM_RDATA[7])}}, $past(MEM_RDATA)}
  ) else $error("Loaded byte not sign-extended into result");

  a_load_addr: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_LOADB_IDX
    && !in_aper
    |=> MEM_REQ && MEM_ADDR == $past(src1_q) + $past(src2_q)
  ) else $error("Load address is not the wrapped sum");

  a_aper_flag: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_LOADB_IDX
    && in_aper |=> aper_q && !MEM_REQ && RESULT_WE
  ) else $error("Aperture byte load went to memory");

  a_cache_touch: assert property (
    CLK_EN && state_q == byte_load_cmp_pkg::S_LOAD && MEM_ACK
    |=> CACHE_TOUCH == $past(MEM_CACHEABLE) && !MEM_REQ
  ) else $error("Cache status update does not follow cacheability");

  a_guard_quiet: assert property (
    exec_go && !guard_q[0]
    |=> !RESULT_WE && !MEM_REQ && !CACHE_TOUCH && $stable(RESULT)
  ) else $error("False guard caused a side effect");

  a_le_reg: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_CMP_LE
    |=> RESULT == {31'h00000000,
        $signed($past(src1_q)) <= $signed($past(src2_q))}
  ) else $error("Register less-or-equal result wrong");

  a_le_imm: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_CMP_LEI
    |=> RESULT == {31'h00000000,
        $signed($past(src1_q)) <= $signed(sext7($past(cmd_q.imm)))}
  ) else $error("Immediate less-or-equal result wrong");

  a_lt_reg: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_CMP_LT
    |=> RESULT == {31'h00000000,
        $signed($past(src1_q)) < $signed($past(src2_q))}
  ) else $error("Register less-than result wrong");

  a_lt_imm: assert property (
    exec_go && guard_q[0] && cmd_q.op == byte_load_cmp_pkg::OP_CMP_LTI
    |=> RESULT == {31'h00000000,
        $signed($past(src1_q)) < $signed(sext7($past(cmd_q.imm)))}
  ) else $error("Immediate less-than result wrong");

  a_cmp_write: assert property (
    exec_go && cmd_q.op != byte_load_cmp_pkg::OP_LOADB_IDX
    && cmd_q.op <= byte_load_cmp_pkg::OP_CMP_LTI
    |=> RESULT_WE == $past(guard_q[0]) ##1 !RESULT_WE || !$past(CLK_EN)
  ) else $error("Compare write does not follow the guard");

endmodule

`default_nettype wire

// file: bench/byte_cache_model.sv
/*
  Behavioural data cache that answers the byte fetches of the engine.
  Assumes one clock; reply delay and contents follow from the address.
*/
`timescale 1ns/1ns
`default_nettype none
module byte_cache_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch port
  input wire logic req,
  input wire logic [31:0] addr,
  output logic ack,
  output logic [7:0] rdata,
  output logic cacheable,
  // Bookkeeping for the bench
  output logic [31:0] last_addr,
  output int n_fetch
);
  int wait_n;
  // Reply after 0 to 9 idle cycles so prompt and slow answers both occur
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      rdata <= 8'h00;
      cacheable <= 1'b0;
      last_addr <= 32'h0;
      n_fetch <= 0;
      wait_n <= 0;
    end else if (req && !ack && wait_n >= 3 * addr[3:2]) begin
      ack <= 1'b1;
      rdata <= addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ addr[31:24] ^ 8'h96;
      cacheable <= addr[5];
      last_addr <= addr;
      n_fetch <= n_fetch + 1;
      wait_n <= 0;
    end else begin
      // Outside a reply the lines toggle each cycle, so the last byte and its inverse alternate
      ack <= 1'b0;
      rdata <= ~rdata;
      cacheable <= ~cacheable;
      wait_n <= (req && !ack) ? wait_n + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// file: bench/signed_byte_load_compare_ops_bench.sv
/*
  Self-checking bench of the byte load and compare engine.
  Assumes the cache model and the map header are on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "byte_load_cmp_map.svh"
module signed_byte_load_compare_ops_bench;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, maddr, res, last_addr, dest = 32'h0;
  logic wreq, mreq, mack, mcach, touch, rwe;
  logic [7:0] mrd;
  int n_fail = 0, comparisons = 0, n_we = 0, n_touch = 0, n_fetch;
  byte_load_cmp u_byte_load_cmp (.SYS_CLK(clk), .RESET_N(rst_n),
    .CLK_EN(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .MEM_REQ(mreq), .MEM_ADDR(maddr),
    .MEM_ACK(mack), .MEM_RDATA(mrd), .MEM_CACHEABLE(mcach),
    .CACHE_TOUCH(touch), .RESULT_WE(rwe), .RESULT(res));
  byte_cache_model u_byte_cache_model (.clk(clk), .rst_n(rst_n),
    .req(mreq), .addr(maddr), .ack(mack), .rdata(mrd), .cacheable(mcach),
    .last_addr(last_addr), .n_fetch(n_fetch));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Count one-cycle pulses towards the register file and the cache
  always @(posedge clk) begin
    if (rwe === 1'b1) n_we <= n_we + 1;
    if (touch === 1'b1) n_touch <= n_touch + 1;
  end
  task automatic report_and_stop();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One bus cycle; waitrequest and read data are taken at the rising edge
  task automatic bus(input logic r, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wd <= d;
    rd <= r;
    wr <= !r;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Idle edge, so the next call never drives in the same time step
    @(posedge clk);
  endtask
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h96;
  endfunction
  task automatic run_op(input logic [31:0] a, b, input logic g,
                        input logic [2:0] op, input logic [6:0] imm);
    logic [31:0] q, ea, sx, exp;
    logic [7:0] mb;
    logic hit, ld;
    int we0, tc0, nf0, n;
    ea = a + b;
    mb = mem_byte(ea);
    sx = {{25{imm[6]}}, imm};
    hit = ea >= `APER_BASE_DEF && ea - `APER_BASE_DEF < `APER_SIZE_DEF;
    ld = op == 3'h0 && g && !hit;
    case (op)
      3'h0: exp = hit ? 32'h0 : {{24{mb[7]}}, mb};
      3'h1: exp = {31'h0, $signed(a) <= $signed(b)};
      3'h2: exp = {31'h0, $signed(a) <= $signed(sx)};
      3'h3: exp = {31'h0, $signed(a) < $signed(b)};
      3'h4: exp = {31'h0, $signed(a) < $signed(sx)};
      default: exp = dest;
    endcase
    if (!g || op > 3'h4) exp = dest;
    we0 = n_we;
    tc0 = n_touch;
    nf0 = n_fetch;
    bus(0, `OFS_SRC1, a, q);
    bus(0, `OFS_SRC2, b, q);
    bus(0, `OFS_GUARD, {$urandom_range(0, 7)} << 1 | {31'h0, g}, q);
    bus(0, `OFS_CMD, {17'h0, imm, 5'h0, op}, q);
    q = 32'h1;
    n = 0;
    while (q[0] !== 1'b0 && n < 100) begin
      bus(1, `OFS_STATUS, 32'h0, q);
      n++;
    end
    if (op < 3'h5) chk({31'h0, q[2]}, {31'h0, !g}, "skip flag");
    if (op == 3'h0 && g) chk({31'h0, q[1]}, {31'h0, hit}, "aper");
    bus(1, `OFS_DEST, 32'h0, q);
    chk(q, exp, "dest");
    chk(res, exp, "result");
    chk(32'(n_we - we0), {31'h0, g && op < 3'h5}, "writes");
    chk(32'(n_touch - tc0), {31'h0, ld && ea[5]}, "touch");
    chk(32'(n_fetch - nf0), {31'h0, ld}, "fetches");
    if (ld) chk(last_addr, ea, "fetch addr");
    dest = exp;
  endtask
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t timeout", $time);
    report_and_stop();
  end
  initial begin
    logic [31:0] q, a;
    int n;
    void'($urandom(32'h5d42c755));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'(4 * i), 32'h0, q);
      chk(q, `RST_WORD, "reset or unmapped");
    end
    bus(0, 8'h18, 32'hffff_ffff, q);
    bus(0, `OFS_DEST, 32'h1234_5678, q);
    bus(1, 8'h18, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    bus(1, `OFS_DEST, 32'h0, q);
    chk(q, 32'h0, "dest ro");
    // Loads: negative index, guard off, aperture edges
    run_op(32'hd00, 32'h2, 1, 3'h0, 7'h00);
    run_op(32'hd04, 32'hffff_fffc, 0, 3'h0, 7'h00);
    run_op(32'hd04, 32'hffff_fffc, 1, 3'h0, 7'h00);
    run_op(32'hd05, 32'hffff_fffc, 1, 3'h0, 7'h00);
    run_op(`APER_BASE_DEF, 32'h0, 1, 3'h0, 7'h00);
    run_op(`APER_BASE_DEF, 32'hffff_ffff, 1, 3'h0, 7'h00);
    a = `APER_BASE_DEF + `APER_SIZE_DEF;
    run_op(a, 32'hffff_ffff, 1, 3'h0, 7'h00);
    run_op(a, 32'h0, 1, 3'h0, 7'h00);
    // A command written during a load stalls until the engine is idle
    n = n_we;
    bus(0, `OFS_CMD, 32'h0, q);
    bus(0, `OFS_CMD, 32'h3, q);
    q = 32'h1;
    while (q[0] !== 1'b0) bus(1, `OFS_STATUS, 32'h0, q);
    bus(1, `OFS_DEST, 32'h0, q);
    dest = {31'h0, $signed(a) < $signed(32'h0)};
    chk(q, dest, "stalled lt");
    chk(32'(n_we - n), 32'h2, "stalled writes");
    // Compares and unused codes 5 to 7: equal, extreme and immediate boundaries
    for (int k = 1; k < 8; k++) begin
      run_op(32'h3, 32'h4, 1, 3'(k), 7'h03);
      run_op(32'h8000_0000, 32'h8000_0000, 1, 3'(k), 7'h40);
      run_op(32'h100, 32'h3, 0, 3'(k), 7'h3f);
      run_op(32'h100, 32'h1000, 1, 3'(k), 7'h3f);
      run_op(32'h3, 32'h3, 1, 3'(k), 7'h02);
      run_op(32'hffff_ffc0, 32'h4, 1, 3'(k), 7'h40);
    end
    // Random mix, some with equal operands
    for (int i = 0; i < 60; i++) begin
      a = $urandom;
      run_op(a, (i % 4 == 0) ? a : $urandom, 1'($urandom_range(0, 3) != 0),
             3'($urandom_range(0, 7)), 7'($urandom));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
